// >>> rtl/smc_pkg.sv
// constants, fields and types shared by the sleep controller files
package smc_pkg;

  // ==========================================================
  // register map (byte offsets on the plain register port)
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_VREG  = 8'h01;
  localparam logic [7:0] REG_STAT  = 8'h02;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] VREG_RST  = 8'h00;
  localparam logic [7:0] CTRL_MASK = 8'h0F;
  localparam logic [7:0] VREG_MASK = 8'h17;
  localparam logic [7:0] RD_ZERO   = 8'h00;

  // ==========================================================
  // field positions
  localparam int SEN_BIT   = 0;
  localparam int SLEEP_MODE_SELECT_LSB = 1;
  localparam int SLEEP_MODE_SELECT_MSB = 3;
  localparam int REGULATOR_POWER_MODE_LSB = 0;
  localparam int REGULATOR_POWER_MODE_MSB = 2;
  localparam int HTLL_BIT  = 4;

  // ==========================================================
  // field encodings
  localparam logic [2:0] SM_IDLE  = 3'h0;
  localparam logic [2:0] SM_STDBY = 3'h1;
  localparam logic [2:0] SM_PDOWN = 3'h2;
  localparam logic [2:0] PM_AUTO  = 3'h0;
  localparam logic [2:0] PM_FULL  = 3'h1;
  localparam logic [1:0] BOD_ACT_WAIT = 2'h3;
  localparam logic [1:0] LUT_FILT_OFF = 2'h0;
  localparam logic [1:0] LUT_EDGE_OFF = 2'h0;

  // ==========================================================
  // timing: base wake latency in peripheral clocks, unlock window
  localparam logic [3:0] WAKE_BASE_CYC = 4'h6;
  localparam logic [3:0] WAKE_LAST     = WAKE_BASE_CYC - 4'h1;
  localparam logic [3:0] WAKE_FIRST    = 4'h1;
  localparam logic [2:0] CCP_WINDOW    = 3'h4;

  // ==========================================================
  // wake source vector positions
  localparam int WK_PIN   = 0;
  localparam int WK_VLM   = 1;
  localparam int WK_MVIO  = 2;
  localparam int WK_RTC   = 3;
  localparam int WK_PIT   = 4;
  localparam int WK_TWI   = 5;
  localparam int WK_CCL   = 6;
  localparam int WK_USART = 7;
  localparam int WK_TCA   = 8;
  localparam int WK_OTHER = 9;
  localparam int NWAKE    = 10;

  // gray along active -> sleep -> wake; wake -> active flips both bits
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'h0,
    ST_SLEEP  = 2'h1,
    ST_WAKE   = 2'h3
  } smc_state_t;

  // only three sleep mode encodings are defined
  function automatic logic smc_mode_ok(input logic [2:0] m);
    smc_mode_ok = (m == SM_IDLE) || (m == SM_STDBY) || (m == SM_PDOWN);
  endfunction

endpackage

// >>> rtl/smc_wake_if.sv
// wake latency handshake between the controller and its timer
`timescale 1ns/1ps
interface smc_wake_if;
  logic start;
  logic need_osc;
  logic need_vreg;
  logic need_bod;
  logic osc_ready;
  logic vreg_ready;
  logic bod_ready;
  logic done;

  modport ctl (output start, need_osc, need_vreg, need_bod,
               output osc_ready, vreg_ready, bod_ready, input done);
  modport tmr (input start, need_osc, need_vreg, need_bod,
               input osc_ready, vreg_ready, bod_ready, output done);
endinterface

// >>> rtl/smc_wake_timer.sv
// wake-up latency timer: base cycles plus oscillator, regulator, brown-out waits
`timescale 1ns/1ps
module smc_wake_timer (
  input wire logic clk_sys,
  input wire logic rst_n,
  smc_wake_if.tmr  wif
);
  import smc_pkg::*;

  logic [3:0] cnt_q;
  logic       busy_q;
  logic       osc_q;
  logic       vreg_q;
  logic       bod_q;
  wire        base_ok;
  wire        extra_ok;

  // ==========================================================
  // completion: every enabled wait is over, base count reached
  assign base_ok  = busy_q && (cnt_q == WAKE_LAST);
  assign extra_ok = (!osc_q || wif.osc_ready) && (!vreg_q || wif.vreg_ready)
                  && (!bod_q || wif.bod_ready);
  assign wif.done = base_ok && extra_ok;

  // needs latched at start; the gates change once waking begins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      osc_q  <= 1'b0;
      vreg_q <= 1'b0;
      bod_q  <= 1'b0;
    end else if (wif.start) begin
      busy_q <= 1'b1;
      osc_q  <= wif.need_osc;
      vreg_q <= wif.need_vreg;
      bod_q  <= wif.need_bod;
    end else if (wif.done) begin
      busy_q <= 1'b0;
    end
  end

  // counter saturates at the last base cycle while waits run
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
    end else if (wif.start) begin
      cnt_q <= WAKE_FIRST;
    end else if (busy_q && cnt_q != WAKE_LAST) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // ==========================================================
  // assertions
  property p_base_latency;
    @(posedge clk_sys) disable iff (!rst_n)
    wif.start && !wif.need_osc && !wif.need_vreg && !wif.need_bod
      |-> ##5 wif.done;
  endproperty
  a_base_latency: assert property (p_base_latency)
    else $error("wake latency is not six cycles");

  property p_no_early_done;
    @(posedge clk_sys) disable iff (!rst_n)
    wif.start |=> !wif.done [*4];
  endproperty
  a_no_early_done: assert property (p_no_early_done)
    else $error("wake finished before the base latency");

  property p_bod_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    busy_q && bod_q && !wif.bod_ready |-> !wif.done;
  endproperty
  a_bod_hold: assert property (p_bod_hold)
    else $error("wake finished before brown-out ready");

endmodule

// >>> rtl/smc_top.sv
// sleep controller: mode select, clock gating, wake sources, protected regulator
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module smc_top #(
  parameter logic [7:0] CCP_IO_REGISTER_KEY_KEY = 8'hA5  // arbitrary value
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output      logic [7:0]               reg_rdata,
  input  wire logic                     ccp_key_wr,
  input  wire logic [7:0]               ccp_key_data,
  input  wire logic                     instr_retire,
  input  wire logic                     sleep_instr,
  input  wire logic [smc_pkg::NWAKE-1:0] wake_irq,
  input  wire logic                     debug_break,
  input  wire logic                     main_run_stdby,
  input  wire logic                     rtc_run_stdby,
  input  wire logic                     ccl_run_stdby,
  input  wire logic                     tca_run_stdby,
  input  wire logic [1:0]               lut_filter_select,
  input  wire logic [1:0]               lut_edge_detect,
  input  wire logic [1:0]               bod_active_mode,
  input  wire logic                     bod_sampled_mode,
  input  wire logic                     wdt_enabled,
  input  wire logic                     pit_enabled,
  input  wire logic                     osc_ready,
  input  wire logic                     vreg_ready,
  input  wire logic                     bod_ready,
  output      logic                     cpu_run,
  output      logic                     sleeping,
  output      logic                     main_clk_en,
  output      logic                     ccl_clk_en,
  output      logic                     tcd_clk_en,
  output      logic                     periph_clk_en,
  output      logic                     rtc_count_en,
  output      logic                     internal_32k_oscillator_en,
  output      logic                     bod_osc_en,
  output      logic                     vreg_low_power,
  output      logic                     hot_leak_en
);
  import smc_pkg::*;

  smc_state_t  state_q;
  smc_state_t  state_d;
  logic [7:0]  ctrl_q;
  logic [7:0]  vreg_q;
  logic [2:0]  mode_q;
  logic [2:0]  win_q;
  logic [2:0]  win_d;
  logic [7:0]  rdata_q;
  logic [8:0]  gate_q;
  logic [8:0]  gate_d;

  smc_wake_if wif ();

  // ==========================================================
  // register decode
  wire        wr_ctrl  = reg_wr && (reg_addr == REG_CTRL);
  wire        wr_vreg  = reg_wr && (reg_addr == REG_VREG) && (win_q != 3'h0);
  wire        key_ok   = ccp_key_wr && (ccp_key_data == CCP_IO_REGISTER_KEY_KEY);
  wire [2:0]  sleep_mode_select    = ctrl_q[SLEEP_MODE_SELECT_MSB:SLEEP_MODE_SELECT_LSB];
  wire        sleep_enable_bit      = ctrl_q[SEN_BIT];
  wire [2:0]  regulator_power_mode    = vreg_q[REGULATOR_POWER_MODE_MSB:REGULATOR_POWER_MODE_LSB];
  wire        pm_auto  = (regulator_power_mode == PM_AUTO);
  // low leakage only acts in automatic mode; the gating keeps it for power-down
  wire        htll     = vreg_q[HTLL_BIT] && pm_auto;
  wire [7:0]  stat_val = {4'h0, state_q, mode_q[1:0]};
  wire [7:0]  rd_mux   = (reg_addr == REG_CTRL) ? ctrl_q :
                         (reg_addr == REG_VREG) ? vreg_q :
                         (reg_addr == REG_STAT) ? stat_val : RD_ZERO;

  // ==========================================================
  // unlock window: opened by the key, closed by retiring instructions
  assign win_d = key_ok ? CCP_WINDOW :
                 (instr_retire && win_q != 3'h0) ? win_q - 3'h1 : win_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      win_q <= 3'h0;
    end else begin
      win_q <= win_d;
    end
  end

  // register writes; protected one ignored outside the window
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      vreg_q <= VREG_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= reg_wdata & CTRL_MASK;
      if (wr_vreg) vreg_q <= reg_wdata & VREG_MASK;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= RD_ZERO;
    end else begin
      rdata_q <= reg_rd ? rd_mux : RD_ZERO;
    end
  end
  assign reg_rdata = rdata_q;

  // ==========================================================
  // wake source qualification by the mode being slept in
  wire m_idle  = (mode_q == SM_IDLE);
  wire m_stdby = (mode_q == SM_STDBY);
  wire m_pdown = (mode_q == SM_PDOWN);
  wire lut_async = (lut_filter_select == LUT_FILT_OFF)
                 && (lut_edge_detect == LUT_EDGE_OFF);

  // port logic raises the pin bit only when asynchronous sensing is set
  wire [NWAKE-1:0] wk_stdby = {1'b0, tca_run_stdby, 1'b1, 1'b1, 1'b1,
                               1'b0, rtc_run_stdby, 1'b1, 1'b1, 1'b1};
  wire [NWAKE-1:0] wk_pdown = {1'b0, 1'b0, 1'b0, lut_async && !htll,
                               !htll, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  wire [NWAKE-1:0] wk_idle  = {1'b1, 1'b1, 1'b0, 1'b1, 1'b1,
                               1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  wire [NWAKE-1:0] wk_mask  = m_idle ? wk_idle :
                              m_stdby ? wk_stdby :
                              m_pdown ? wk_pdown : '0;
  // a debug break wakes even with no interrupt pending
  wire wake_req = (|(wake_irq & wk_mask)) || debug_break;

  // ==========================================================
  // sleep sequencing
  wire enter = sleep_instr && sleep_enable_bit && smc_mode_ok(sleep_mode_select);
  assign wif.start = (state_q == ST_SLEEP) && wake_req;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_ACTIVE: begin
        if (enter) state_d = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (wake_req) state_d = ST_WAKE;
      end
      ST_WAKE: begin
        if (wif.done) state_d = ST_ACTIVE;
      end
      default: begin
        state_d = ST_ACTIVE;
      end
    endcase
  end

  // mode captured on entry so later writes cannot shift the gating
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_ACTIVE;
      mode_q  <= SM_IDLE;
    end else begin
      state_q <= state_d;
      if (state_q == ST_ACTIVE && enter) mode_q <= sleep_mode_select;
    end
  end

  // ==========================================================
  // clock and power gating, computed for the next state
  wire [2:0] mode_n = (state_q == ST_ACTIVE && enter) ? sleep_mode_select : mode_q;
  wire asleep_n = (state_d == ST_SLEEP);
  wire idle_n   = !asleep_n || (mode_n == SM_IDLE);
  wire stdby_n  = asleep_n && (mode_n == SM_STDBY);
  wire pdown_n  = asleep_n && (mode_n == SM_PDOWN);
  wire main_n   = idle_n || (stdby_n && main_run_stdby);
  wire lowreg_n = pm_auto && (stdby_n || pdown_n) && !main_n;

  assign gate_d = {
    htll && pdown_n,                                                        // low leakage
    lowreg_n,                                                               // regulator low
    bod_sampled_mode,
    !pdown_n || wdt_enabled || bod_sampled_mode || pit_enabled,
    idle_n || (stdby_n && rtc_run_stdby),
    idle_n,                                                                 // other periphs
    idle_n,                                                                 // waveform timer
    idle_n || (stdby_n && ccl_run_stdby),
    main_n
  };

  // registered so gate outputs never glitch on decode
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gate_q <= 9'h07F;
    end else begin
      gate_q <= gate_d;
    end
  end

  assign main_clk_en    = gate_q[0];
  assign ccl_clk_en     = gate_q[1];
  assign tcd_clk_en     = gate_q[2];
  assign periph_clk_en  = gate_q[3];
  assign rtc_count_en   = gate_q[4];
  assign internal_32k_oscillator_en      = gate_q[5];
  assign bod_osc_en     = gate_q[6];
  assign vreg_low_power = gate_q[7];
  assign hot_leak_en    = gate_q[8];
  assign cpu_run        = (state_q == ST_ACTIVE);
  assign sleeping       = (state_q == ST_SLEEP);

  // ==========================================================
  // wake latency timer; extra waits for a stopped main clock or lowered regulator, and for brown-out when set to wait
  assign wif.need_osc   = !main_clk_en;
  assign wif.need_vreg  = vreg_low_power;
  assign wif.need_bod   = (bod_active_mode == BOD_ACT_WAIT);
  assign wif.osc_ready  = osc_ready;
  assign wif.vreg_ready = vreg_ready;
  assign wif.bod_ready  = bod_ready;

  smc_wake_timer u_timer (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .wif     (wif)
  );

  // ==========================================================
  // assertions
  property p_prot_block;
    @(posedge clk_sys) disable iff (!rst_n)
    reg_wr && reg_addr == REG_VREG && win_q == 3'h0 |=> vreg_q == $past(vreg_q);
  endproperty
  a_prot_block: assert property (p_prot_block)
    else $error("protected register changed without unlock");

  property p_key_window;
    @(posedge clk_sys) disable iff (!rst_n)
    key_ok ##1 (instr_retire && !ccp_key_wr) [*4] |=> win_q == 3'h0;
  endproperty
  a_key_window: assert property (p_key_window)
    else $error("unlock window not closed after four instructions");

  property p_reserved_mode;
    @(posedge clk_sys) disable iff (!rst_n)
    state_q == ST_ACTIVE && sleep_instr && !smc_mode_ok(sleep_mode_select) |=> state_q == ST_ACTIVE;
  endproperty
  a_reserved_mode: assert property (p_reserved_mode)
    else $error("slept on a reserved mode");

  property p_need_sen;
    @(posedge clk_sys) disable iff (!rst_n)
    state_q == ST_ACTIVE && sleep_instr && !sleep_enable_bit |=> cpu_run;
  endproperty
  a_need_sen: assert property (p_need_sen)
    else $error("slept without sleep enable");

  property p_debug_wake;
    @(posedge clk_sys) disable iff (!rst_n)
    sleeping && debug_break |=> state_q == ST_WAKE;
  endproperty
  a_debug_wake: assert property (p_debug_wake)
    else $error("debug break did not wake");

  property p_pdown_gates;
    @(posedge clk_sys) disable iff (!rst_n)
    sleeping && m_pdown |-> !main_clk_en && !ccl_clk_en && !tcd_clk_en;
  endproperty
  a_pdown_gates: assert property (p_pdown_gates)
    else $error("high-frequency clock on in power-down");

  property p_idle_main;
    @(posedge clk_sys) disable iff (!rst_n)
    sleeping && m_idle |-> main_clk_en && tcd_clk_en;
  endproperty
  a_idle_main: assert property (p_idle_main)
    else $error("main clock stopped in idle");

  property p_twi_htll;
    @(posedge clk_sys) disable iff (!rst_n)
    sleeping && m_pdown && htll && !debug_break && wake_irq == (10'h001 << WK_TWI)
      |=> sleeping;
  endproperty
  a_twi_htll: assert property (p_twi_htll)
    else $error("address match woke low leakage power-down");

  property p_stdby_ccl;
    @(posedge clk_sys) disable iff (!rst_n)
    sleeping && m_stdby && !ccl_run_stdby |-> !ccl_clk_en;
  endproperty
  a_stdby_ccl: assert property (p_stdby_ccl)
    else $error("logic cell clock on in standby");

  c_idle_wake: cover property (@(posedge clk_sys) disable iff (!rst_n)
    sleeping && m_idle ##1 state_q == ST_WAKE ##5 cpu_run);
  c_pdown_wake: cover property (@(posedge clk_sys) disable iff (!rst_n)
    sleeping && m_pdown && wake_irq[WK_PIN]);
  c_prot_write: cover property (@(posedge clk_sys) disable iff (!rst_n)
    wr_vreg);

endmodule

// >>> test/smc_ready_model.sv
// start-up ready model of the main oscillator, regulator and brown-out partners
`timescale 1ns/1ps
module smc_ready_model (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic slow,
  input  wire logic main_clk_en,
  input  wire logic vreg_low_power,
  input  wire logic sleeping,
  output      logic osc_ready,
  output      logic vreg_ready,
  output      logic bod_ready
);
  logic [4:0] osc_q;
  logic [4:0] vreg_q;
  logic [4:0] bod_q;
  logic [4:0] dly;
  // ==========================================================
  // ready levels: slow mode makes a source lag 12 cycles after it is switched back on
  assign dly        = slow ? 5'h0C : 5'h00;
  assign osc_ready  = main_clk_en && (osc_q >= dly);
  assign vreg_ready = !vreg_low_power && (vreg_q >= dly);
  assign bod_ready  = !sleeping && (bod_q >= dly);
  // counters restart whenever a source is switched off, then saturate
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      osc_q  <= 5'h00;
      vreg_q <= 5'h00;
      bod_q  <= 5'h00;
    end else begin
      osc_q  <= !main_clk_en ? 5'h00 : osc_q + 5'(osc_q != 5'h1F);
      vreg_q <= vreg_low_power ? 5'h00 : vreg_q + 5'(vreg_q != 5'h1F);
      bod_q  <= sleeping ? 5'h00 : bod_q + 5'(bod_q != 5'h1F);
    end
  end
endmodule

// >>> test/smc_top_tb.sv
// self-checking bench for the sleep controller top
`timescale 1ns/1ps
module smc_top_tb;
  import smc_pkg::*;
  // ==========================================================
  // signals
  localparam logic [7:0] KEY = 8'h3C;  // arbitrary unlock value
  logic             clk_sys, rst_n, reg_wr, reg_rd, ccp_key_wr, instr_retire, sleep_instr;
  logic [7:0]       reg_addr, reg_wdata, ccp_key_data, reg_rdata;
  logic [NWAKE-1:0] wake_irq;
  logic             debug_break, main_run_stdby, rtc_run_stdby, ccl_run_stdby, tca_run_stdby;
  logic [1:0]       lut_filter_select, lut_edge_detect, bod_active_mode;
  logic             bod_sampled_mode, wdt_enabled, pit_enabled, slow, ll, as, ok;
  logic             osc_ready, vreg_ready, bod_ready, cpu_run, sleeping, main_clk_en;
  logic             ccl_clk_en, tcd_clk_en, periph_clk_en, rtc_count_en, internal_32k_oscillator_en;
  logic             bod_osc_en, vreg_low_power, hot_leak_en;
  logic [2:0]       md;
  logic [8:0]       gates;
  int               fail_count, compares, n;
  assign gates = {main_clk_en, ccl_clk_en, tcd_clk_en, periph_clk_en, rtc_count_en,
                  internal_32k_oscillator_en, bod_osc_en, vreg_low_power, hot_leak_en};
  smc_top #(.CCP_IO_REGISTER_KEY_KEY(KEY)) u_dut (.clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .ccp_key_wr, .ccp_key_data, .instr_retire, .sleep_instr, .wake_irq,
    .debug_break, .main_run_stdby, .rtc_run_stdby, .ccl_run_stdby, .tca_run_stdby,
    .lut_filter_select, .lut_edge_detect, .bod_active_mode, .bod_sampled_mode, .wdt_enabled,
    .pit_enabled, .osc_ready, .vreg_ready, .bod_ready, .cpu_run, .sleeping, .main_clk_en,
    .ccl_clk_en, .tcd_clk_en, .periph_clk_en, .rtc_count_en, .internal_32k_oscillator_en, .bod_osc_en,
    .vreg_low_power, .hot_leak_en);
  smc_ready_model u_ready (.clk_sys, .rst_n, .slow, .main_clk_en, .vreg_low_power, .sleeping,
    .osc_ready, .vreg_ready, .bod_ready);
  // ==========================================================
  // expectations: gate order main,ccl,tcd,periph,rtc,internal_32k_oscillator,bod_osc,vreg_low,hot
  function automatic logic [8:0] exp_gates(input logic [2:0] m, input logic l);
    case (m)
      SM_IDLE:  exp_gates = {6'h3F, bod_sampled_mode, 2'h0};
      SM_STDBY: exp_gates = {main_run_stdby, ccl_run_stdby, 2'h0, rtc_run_stdby, 1'b1,
                             bod_sampled_mode, !main_run_stdby, 1'b0};
      default:  exp_gates = {5'h00, wdt_enabled | bod_sampled_mode | pit_enabled,
                             bod_sampled_mode, 1'b1, l};
    endcase
  endfunction
  function automatic logic wake_ok(input logic [2:0] m, input int b, input logic l, a);
    case (m)
      SM_IDLE:  wake_ok = (b != WK_USART);
      SM_STDBY: wake_ok = (b inside {WK_PIN, WK_VLM, WK_MVIO, WK_TWI, WK_CCL, WK_USART})
                || (b == WK_RTC && rtc_run_stdby) || (b == WK_TCA && tca_run_stdby);
      default:  wake_ok = (b inside {WK_PIN, WK_VLM, WK_MVIO, WK_PIT})
                || (b == WK_TWI && !l) || (b == WK_CCL && a && !l);
    endcase
  endfunction
  // ==========================================================
  // bus and core tasks; every request changes right after a rising edge
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(16'(reg_rdata), 16'(e));
  endtask
  // key cycle, then r retired instructions before the caller's write
  task automatic unlock(input logic [7:0] k, input int r);
    @(posedge clk_sys);
    ccp_key_data <= k;
    ccp_key_wr <= 1'b1;
    @(posedge clk_sys);
    ccp_key_wr <= 1'b0;
    repeat (r) begin
      instr_retire <= 1'b1;
      @(posedge clk_sys);
    end
    instr_retire <= 1'b0;
  endtask
  task automatic go_sleep(input logic [7:0] c);
    wr(REG_CTRL, c);
    @(posedge clk_sys);
    sleep_instr <= 1'b1;
    @(posedge clk_sys);
    sleep_instr <= 1'b0;
    @(negedge clk_sys);
  endtask
  // raise {debug, irqs}; n counts cycles from the cause until the core runs
  task automatic wake(input logic [NWAKE:0] v);
    @(posedge clk_sys);
    {debug_break, wake_irq} <= v;
    n = 0;
    @(negedge clk_sys);
    while (!cpu_run && n < 40) begin
      n++;
      @(negedge clk_sys);
    end
    @(posedge clk_sys);
    {debug_break, wake_irq} <= '0;
    @(negedge clk_sys);
  endtask
  task automatic conclude();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================================
  // clock, watchdog, main sequence
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (30000) @(posedge clk_sys);
    fail_count++;
    conclude();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, ccp_key_wr, instr_retire, sleep_instr, debug_break, slow} = '0;
    {reg_addr, reg_wdata, ccp_key_data, wake_irq, lut_filter_select, lut_edge_detect} = '0;
    {main_run_stdby, rtc_run_stdby, ccl_run_stdby, tca_run_stdby, bod_active_mode} = '0;
    {bod_sampled_mode, wdt_enabled, pit_enabled} = '0;
    void'($urandom(32'hE45F));
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(REG_CTRL, CTRL_RST);
    rd(REG_VREG, VREG_RST);
    rd(8'h07, RD_ZERO);
    n = $urandom;
    wr(REG_CTRL, 8'(n));
    rd(REG_CTRL, 8'(n) & CTRL_MASK);
    wr(REG_VREG, 8'h11);
    rd(REG_VREG, 8'h00);
    unlock(~KEY, 0);
    wr(REG_VREG, 8'h11);
    rd(REG_VREG, 8'h00);
    unlock(KEY, 3);
    wr(REG_VREG, 8'hF1);
    rd(REG_VREG, 8'h11);
    unlock(KEY, 4);
    wr(REG_VREG, 8'h00);
    rd(REG_VREG, 8'h11);
    $display("register and unlock test done");
    // sleep enable clear, or a reserved mode with it set, keeps the core running
    for (int m = 0; m < 8; m++) begin
      go_sleep({4'h0, 3'(m), m > 2});
      chk(16'({cpu_run, sleeping}), 16'h0002);
    end
    $display("refused sleep test done");
    for (int m = 0; m < 3; m++) begin
      for (int b = 0; b < NWAKE; b++) begin
        md = 3'(m);
        ll = (md == SM_PDOWN) && ($urandom_range(1) != 0);
        as = ($urandom_range(1) != 0);
        @(posedge clk_sys);
        {main_run_stdby, rtc_run_stdby, ccl_run_stdby, tca_run_stdby} <= 4'($urandom);
        {bod_sampled_mode, wdt_enabled, pit_enabled} <= 3'($urandom);
        lut_filter_select <= as ? 2'h0 : 2'($urandom_range(3, 1));
        lut_edge_detect <= as ? 2'h0 : 2'($urandom);
        bod_active_mode <= 2'($urandom);
        unlock(KEY, 0);
        wr(REG_VREG, {3'h0, ll, 4'h0});
        go_sleep({4'h0, md, 1'b1});
        chk(16'({cpu_run, sleeping}), 16'h0001);
        chk(16'(gates), 16'(exp_gates(md, ll)));
        ok = wake_ok(md, b, ll, as);
        wake(11'(1 << b));
        chk(16'(n < 40), 16'(ok));
        if (!ok) begin
          wake(11'h400);
        end
        chk(16'(n), 16'h0006);
        chk(16'(gates), 16'(exp_gates(SM_IDLE, 1'b0)));
      end
    end
    $display("wake source test done");
    // slow partner: idle adds nothing, brown-out wait and stopped clock stretch it
    slow <= 1'b1;
    // full drive keeps low leakage clear before standby, and keeps the regulator up
    unlock(KEY, 0);
    wr(REG_VREG, {4'h0, 1'b0, PM_FULL});
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      bod_active_mode <= (i == 1) ? BOD_ACT_WAIT : 2'h0;
      main_run_stdby <= 1'b0;
      go_sleep({4'h0, (i == 2) ? SM_STDBY : SM_IDLE, 1'b1});
      chk(16'(vreg_low_power), 16'h0000);
      wake(11'h001);
      chk(16'(n == 6), 16'(i == 0));
      chk(16'(n < 40), 16'h0001);
    end
    $display("latency test done");
    go_sleep({4'h0, SM_STDBY, 1'b1});
    @(posedge clk_sys);
    rst_n <= 1'b0;
    @(negedge clk_sys);
    chk(16'(gates), 16'h01FC);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk(16'({cpu_run, sleeping}), 16'h0002);
    rd(REG_CTRL, CTRL_RST);
    $display("reset in sleep test done");
    conclude();
  end
endmodule
